/* verilog/pmpc_params.svh */
// Constants for the port mode and optical protection controller
// Summary of operation
// RULE1: No mode setting asserted: all four ports form one learning switch.
// RULE2: First setting selects dual channel; all mode settings default off.
// RULE3: Dual channel pairs each optical port with one copper port, never crossing.
// RULE4: Second setting selects one-plus-one optical protection, non-reverting.
// RULE5: Third setting selects one-plus-one optical protection, reverting.
// RULE6: Protection connects the primary optical port to copper ports as working link.
// RULE7: Standby optical port stays active but is connected to no other port.
// RULE8: Standby optical port keeps link up, carrying no user frames.
// RULE9: Fault on working primary moves all user traffic to the standby port.
// RULE10: Non-reverting stays on standby until it fails, then returns to primary.
// RULE11: Reverting returns traffic to primary once its fault clears.
// RULE12: Protection covers only the optical ports, never the copper ports.
// RULE13: Conflicting settings: reverting first, then non-reverting, then dual.
// RULE14: Link loss or module fault flag counts as a port fault.
`ifndef PMPC_PARAMS_SVH
`define PMPC_PARAMS_SVH

`define PMPC_CLK_MHZ        25
`define PMPC_TICK_US        1000
`define PMPC_TICK_CYCLES    (`PMPC_TICK_US * `PMPC_CLK_MHZ)
`define PMPC_CNT_W          16

`define PMPC_ADDR_W         8
`define PMPC_OFS_STATUS     8'h00
`define PMPC_OFS_HOLD       8'h04
`define PMPC_OFS_INT_STAT   8'h08
`define PMPC_OFS_INT_MASK   8'h0C

`define PMPC_HOLD_RST       16'h000A
`define PMPC_MASK_RST       4'h0
`define PMPC_FWD_SW_PRI     4'hE
`define PMPC_FWD_SW_SEC     4'hD
`define PMPC_FWD_SW_CUA     4'hB
`define PMPC_FWD_SW_CUB     4'h7

`define PMPC_ST_MODE        0
`define PMPC_ST_STANDBY     2
`define PMPC_ST_PRI_UP      3
`define PMPC_ST_SEC_UP      4
`define PMPC_ST_CUA_UP      5
`define PMPC_ST_CUB_UP      6
`define PMPC_ST_PRI_FAULT   7
`define PMPC_ST_SEC_FAULT   8
`define PMPC_ST_SPARE_A     9
`define PMPC_ST_SPARE_B     10

`define PMPC_INT_FAILOVER   0
`define PMPC_INT_RESTORE    1
`define PMPC_INT_MODE       2
`define PMPC_INT_PRI_FAULT  3
`define PMPC_INT_W          4

`define PMPC_PORT_PRI       0
`define PMPC_PORT_SEC       1
`define PMPC_PORT_CUA       2
`define PMPC_PORT_CUB       3

`endif

/* verilog/pmpc_pkg.sv */
// Types shared by the port mode controller and its fault filter
`include "pmpc_params.svh"

package pmpc_pkg;

  typedef enum logic [1:0] {
    PMPC_MODE_SWITCH = 2'h0,
    PMPC_MODE_DUAL   = 2'h1,
    PMPC_MODE_NONREV = 2'h3,
    PMPC_MODE_REVERT = 2'h2
  } pmpc_mode_t;

  typedef struct packed {
    logic                   faulted;
    logic [`PMPC_CNT_W-1:0] cnt;
  } pmpc_filt_t;

  typedef struct packed {
    pmpc_mode_t             mode;
    logic                   onStandby;
    logic [`PMPC_CNT_W-1:0] tickCnt;
    logic                   tick;
    logic [`PMPC_CNT_W-1:0] hold;
    logic [`PMPC_INT_W-1:0] intStat;
    logic [`PMPC_INT_W-1:0] intMask;
    logic                   irq;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [3:0]             fwdPri;
    logic [3:0]             fwdSec;
    logic [3:0]             fwdCuA;
    logic [3:0]             fwdCuB;
    logic                   activePri;
    logic                   activeSec;
    logic                   standbySec;
    logic                   priFaultSeen;
  } pmpc_state_t;

endpackage

/* verilog/pmpc_fault_filter.sv */
// Per-port fault detector with a hold time before a fault clears
`timescale 1ns/1ns
`include "pmpc_params.svh"

module pmpc_fault_filter
  import pmpc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstN,
  input  wire logic                   tick,
  input  wire logic                   linkUp,
  input  wire logic                   moduleFault,
  input  wire logic [`PMPC_CNT_W-1:0] holdTicks,
  output wire logic                   faulted
);

  pmpc_filt_t s;
  pmpc_filt_t next_s;
  logic       raw;

  always_comb begin
    next_s = s;
    // RULE14: link loss or flag
    raw = !linkUp || moduleFault;
    if (raw) begin
      // Assert at once so failover is not delayed
      next_s.faulted = 1'b1;
      next_s.cnt     = '0;
    end else if (s.faulted) begin
      if (s.cnt >= holdTicks) begin
        next_s.faulted = 1'b0;
        next_s.cnt     = '0;
      end else if (tick) begin
        next_s.cnt = s.cnt + `PMPC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s <= '{faulted: 1'b1, cnt: '0};
    end else begin
      s <= next_s;
    end
  end

  assign faulted = s.faulted;

endmodule

/* verilog/pmpc_port_mode_ctrl.sv */
// Port mode selection and optical one-plus-one protection with APB registers
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "pmpc_params.svh"

module pmpc_port_mode_ctrl
  import pmpc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PMPC_TICK_CYCLES
)
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,

  input  wire logic                   cfgDual,
  input  wire logic                   cfgProtNonRev,
  input  wire logic                   cfgProtRevert,
  input  wire logic                   spareSettingA,
  input  wire logic                   spareSettingB,

  input  wire logic                   primaryOpticalLinkUp,
  input  wire logic                   primaryOpticalFault,
  input  wire logic                   standbyOpticalLinkUp,
  input  wire logic                   standbyOpticalFault,
  input  wire logic                   copperALinkUp,
  input  wire logic                   copperBLinkUp,

  output wire logic [3:0]             fwdPri,
  output wire logic [3:0]             fwdSec,
  output wire logic [3:0]             fwdCuA,
  output wire logic [3:0]             fwdCuB,
  output wire logic                   activePri,
  output wire logic                   activeSec,
  output wire logic                   standbySec,

  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`PMPC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output wire logic [31:0]            prdata,
  output wire logic                   pready,
  output wire logic                   pslverr,

  output wire logic                   irq
);

  // Divider wraps after TICK_CYCLES clocks
  localparam logic [`PMPC_CNT_W-1:0] TICK_LAST = `PMPC_CNT_W'(TICK_CYCLES - 1);

  // One constant reset image keeps the async branch free of logic
  localparam pmpc_state_t RST_STATE = '{
    mode:         PMPC_MODE_SWITCH,
    onStandby:    1'b0,
    tickCnt:      '0,
    tick:         1'b0,
    hold:         `PMPC_HOLD_RST,
    intStat:      '0,
    intMask:      `PMPC_MASK_RST,
    irq:          1'b0,
    prdata:       32'h0,
    pready:       1'b0,
    pslverr:      1'b0,
    fwdPri:       `PMPC_FWD_SW_PRI,
    fwdSec:       `PMPC_FWD_SW_SEC,
    fwdCuA:       `PMPC_FWD_SW_CUA,
    fwdCuB:       `PMPC_FWD_SW_CUB,
    activePri:    1'b1,
    activeSec:    1'b1,
    standbySec:   1'b0,
    priFaultSeen: 1'b1
  };

  logic [1:0]  rstSync;
  logic        rstN;

  pmpc_state_t s;
  pmpc_state_t next_s;

  logic        priFault;
  logic        secFault;
  logic [1:0]  optLinkUp;
  logic [1:0]  optFault;
  logic [1:0]  optFaulted;

  logic        protMode;
  pmpc_mode_t  selMode;
  logic        evFailover;
  logic        evRestore;
  logic        evMode;
  logic        evPriFault;
  logic [`PMPC_INT_W-1:0] events;

  logic        setup;
  logic        done;
  logic        hit;
  logic [31:0] rdMux;
  logic [15:0] fwdAll;

  // Async assert, clocked release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // Everything below runs on the released copy of the reset
  assign rstN = rstSync[1];

  // Same hold time for both optical ports; index follows the port numbering
  assign optLinkUp = {standbyOpticalLinkUp, primaryOpticalLinkUp};
  assign optFault  = {standbyOpticalFault, primaryOpticalFault};

  for (genvar p = 0; p < 2; p++) begin : g_filt
    pmpc_fault_filter uFilt (
      .clk         (clk),
      .rstN        (rstN),
      .tick        (s.tick),
      .linkUp      (optLinkUp[p]),
      .moduleFault (optFault[p]),
      .holdTicks   (s.hold),
      .faulted     (optFaulted[p])
    );
  end

  assign priFault = optFaulted[`PMPC_PORT_PRI];
  assign secFault = optFaulted[`PMPC_PORT_SEC];

  // Forwarding masks, four bits per source port, indexed by port number
  function automatic logic [15:0] fwdFor(input pmpc_mode_t m, input logic onSb);
    logic [3:0] pri;
    logic [3:0] sec;
    logic [3:0] cua;
    logic [3:0] cub;
    pri = 4'h0;
    sec = 4'h0;
    cua = 4'h0;
    cub = 4'h0;
    case (m)
      PMPC_MODE_DUAL: begin
        // RULE3: pairs stay isolated
        pri = 4'h4;
        cua = 4'h1;
        sec = 4'h8;
        cub = 4'h2;
      end
      PMPC_MODE_NONREV, PMPC_MODE_REVERT: begin
        // RULE12: copper always plain drops
        cua = 4'h8;
        cub = 4'h4;
        if (!onSb) begin
          // RULE6: primary is the working link
          pri = 4'hC;
          cua = cua | 4'h1;
          cub = cub | 4'h1;
        end else begin
          // RULE9: traffic on standby port
          sec = 4'hC;
          cua = cua | 4'h2;
          cub = cub | 4'h2;
        end
      end
      default: begin
        // RULE1: full four-port switch
        pri = `PMPC_FWD_SW_PRI;
        sec = `PMPC_FWD_SW_SEC;
        cua = `PMPC_FWD_SW_CUA;
        cub = `PMPC_FWD_SW_CUB;
      end
    endcase
    return {cub, cua, sec, pri};
  endfunction

  always_comb begin
    next_s = s;

    // RULE13: fixed priority among settings
    if (cfgProtRevert) begin
      // RULE5: reverting protection
      selMode = PMPC_MODE_REVERT;
    end else if (cfgProtNonRev) begin
      // RULE4: non-reverting protection
      selMode = PMPC_MODE_NONREV;
    end else if (cfgDual) begin
      // RULE2: dual channel setting
      selMode = PMPC_MODE_DUAL;
    end else begin
      selMode = PMPC_MODE_SWITCH;
    end

    protMode   = (s.mode == PMPC_MODE_NONREV) || (s.mode == PMPC_MODE_REVERT);
    evFailover = 1'b0;
    evRestore  = 1'b0;
    evMode     = 1'b0;
    // Edge detector starts high so the reset fault is not reported
    evPriFault = priFault && !s.priFaultSeen;
    next_s.priFaultSeen = priFault;

    // Millisecond enable for the hold timers
    if (s.tickCnt >= TICK_LAST) begin
      next_s.tickCnt = '0;
      next_s.tick    = 1'b1;
    end else begin
      next_s.tickCnt = s.tickCnt + `PMPC_CNT_W'(1);
      next_s.tick    = 1'b0;
    end

    // Settings are switch levels; no debounce is done here
    next_s.mode = selMode;
    if (selMode != s.mode) begin
      // A new mode always starts on the primary
      evMode           = 1'b1;
      next_s.onStandby = 1'b0;
    end else if (protMode) begin
      case (s.onStandby)
        1'b0: begin
          // RULE9: fail over only to a healthy standby
          if (priFault && !secFault) begin
            next_s.onStandby = 1'b1;
            evFailover       = 1'b1;
          end
        end
        default: begin
          if (s.mode == PMPC_MODE_REVERT) begin
            // RULE11: back once primary is clear
            if (!priFault) begin
              next_s.onStandby = 1'b0;
              evRestore        = 1'b1;
            end
          end else begin
            // RULE10: stay until standby fails
            if (secFault && !priFault) begin
              next_s.onStandby = 1'b0;
              evRestore        = 1'b1;
            end
          end
        end
      endcase
    end

    // Masks follow the next mode so they move with the state bits
    fwdAll        = fwdFor(next_s.mode, next_s.onStandby);
    next_s.fwdPri = fwdAll[3:0];
    next_s.fwdSec = fwdAll[7:4];
    next_s.fwdCuA = fwdAll[11:8];
    next_s.fwdCuB = fwdAll[15:12];

    // RULE7: standby keeps MAC enabled, no forwarding
    next_s.activePri = (next_s.mode == PMPC_MODE_SWITCH) ||
                       (next_s.mode == PMPC_MODE_DUAL) || !next_s.onStandby;
    next_s.activeSec = (next_s.mode == PMPC_MODE_SWITCH) ||
                       (next_s.mode == PMPC_MODE_DUAL) || next_s.onStandby;
    // RULE8: standby port held in link state
    next_s.standbySec = !next_s.activeSec;

    // Event bits line up with the interrupt status layout
    events = '0;
    events[`PMPC_INT_FAILOVER]  = evFailover;
    events[`PMPC_INT_RESTORE]   = evRestore;
    events[`PMPC_INT_MODE]      = evMode;
    events[`PMPC_INT_PRI_FAULT] = evPriFault;

    // APB: answer is prepared in setup, taken at the first access edge
    // Zero wait states; the access phase is never stretched
    setup = psel && !penable;
    done  = psel && penable && s.pready;

    // Unmapped or unaligned offsets answer with an error
    hit   = 1'b1;
    rdMux = 32'h0;
    if (paddr == `PMPC_OFS_STATUS) begin
      rdMux[`PMPC_ST_MODE +: 2]   = s.mode;
      rdMux[`PMPC_ST_STANDBY]     = s.onStandby;
      rdMux[`PMPC_ST_PRI_UP]      = primaryOpticalLinkUp;
      rdMux[`PMPC_ST_SEC_UP]      = standbyOpticalLinkUp;
      rdMux[`PMPC_ST_CUA_UP]      = copperALinkUp;
      rdMux[`PMPC_ST_CUB_UP]      = copperBLinkUp;
      rdMux[`PMPC_ST_PRI_FAULT]   = priFault;
      rdMux[`PMPC_ST_SEC_FAULT]   = secFault;
      rdMux[`PMPC_ST_SPARE_A]     = spareSettingA;
      rdMux[`PMPC_ST_SPARE_B]     = spareSettingB;
    end else if (paddr == `PMPC_OFS_HOLD) begin
      rdMux[`PMPC_CNT_W-1:0] = s.hold;
    end else if (paddr == `PMPC_OFS_INT_STAT) begin
      // Include this cycle's events so the clear cannot drop them
      rdMux[`PMPC_INT_W-1:0] = s.intStat | events;
    end else if (paddr == `PMPC_OFS_INT_MASK) begin
      rdMux[`PMPC_INT_W-1:0] = s.intMask;
    end else begin
      hit = 1'b0;
    end

    if (setup) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !hit;
      next_s.prdata  = (pwrite || !hit) ? 32'h0 : rdMux;
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0;
    end

    // Writes to read-only offsets are dropped without an error
    if (done && pwrite) begin
      if (paddr == `PMPC_OFS_HOLD) begin
        next_s.hold = pwdata[`PMPC_CNT_W-1:0];
      end else if (paddr == `PMPC_OFS_INT_MASK) begin
        next_s.intMask = pwdata[`PMPC_INT_W-1:0];
      end
    end

    // Read clears, but a new event wins over the clear
    if (done && !pwrite && (paddr == `PMPC_OFS_INT_STAT)) begin
      next_s.intStat = events;
    end else begin
      next_s.intStat = s.intStat | events;
    end

    // Level output taken from the next image so it leaves a flop
    next_s.irq = |(next_s.intStat & next_s.intMask);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign fwdPri     = s.fwdPri;
  assign fwdSec     = s.fwdSec;
  assign fwdCuA     = s.fwdCuA;
  assign fwdCuB     = s.fwdCuB;
  assign activePri  = s.activePri;
  assign activeSec  = s.activeSec;
  assign standbySec = s.standbySec;
  assign prdata     = s.prdata;
  assign pready     = s.pready;
  assign pslverr    = s.pslverr;
  assign irq        = s.irq;

endmodule

/* tb/pmpc_port_mode_monitor.sv */
// Assertion checker for the port mode and protection controller
`timescale 1ns/1ns
`include "pmpc_params.svh"

module pmpc_port_mode_monitor (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    cfgDual,
  input wire logic                    cfgProtNonRev,
  input wire logic                    cfgProtRevert,
  input wire logic                    primaryOpticalLinkUp,
  input wire logic                    primaryOpticalFault,
  input wire logic                    standbyOpticalLinkUp,
  input wire logic                    standbyOpticalFault,
  input wire logic [3:0]              fwdPri,
  input wire logic [3:0]              fwdSec,
  input wire logic [3:0]              fwdCuA,
  input wire logic [3:0]              fwdCuB,
  input wire logic                    activePri,
  input wire logic                    activeSec,
  input wire logic                    standbySec,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [`PMPC_ADDR_W-1:0] paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr
);
  logic [1:0] up;
  logic       rdy;
  logic       prot;
  logic       secOk;
  logic       priBad;

  // Outputs only follow the settings once the synchronised reset has ended
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
    end else if (up != 2'h2) begin
      up <= up + 2'h1;
    end
  end
  assign rdy = (up == 2'h2);
  assign prot = cfgProtNonRev || cfgProtRevert;
  assign secOk = standbyOpticalLinkUp && !standbyOpticalFault;
  assign priBad = !primaryOpticalLinkUp || primaryOpticalFault;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !rdy);

  sw_mode_a: assert property (!cfgDual && !prot |=> fwdPri == 4'hE
    && fwdSec == 4'hD && fwdCuA == 4'hB && fwdCuB == 4'h7) else $error("switch map wrong");
  dual_pair_a: assert property (cfgDual && !prot |=> fwdPri == 4'h4
    && fwdSec == 4'h8 && fwdCuA == 4'h1 && fwdCuB == 4'h2) else $error("dual map wrong");
  work_map_a: assert property (activePri && !activeSec |-> fwdPri == 4'hC
    && fwdSec == 4'h0 && fwdCuA == 4'h9 && fwdCuB == 4'h5) else $error("working map wrong");
  fail_map_a: assert property (activeSec && !activePri |-> fwdPri == 4'h0
    && fwdSec == 4'hC && fwdCuA == 4'hA && fwdCuB == 4'h6 && !standbySec)
    else $error("failover map wrong");
  standby_idle_a: assert property (standbySec |-> activePri && !activeSec
    && !fwdCuA[1] && !fwdCuB[1]) else $error("standby carries traffic");
  failover_a: assert property (secOk ##1 (prot && standbySec && priBad && secOk)
    ##1 (secOk && $stable({cfgDual, prot})) |=> activeSec && !activePri)
    else $error("no failover");
  prot_one_a: assert property (prot |=> !(activePri && activeSec))
    else $error("protection priority lost");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing wrong");
  apb_err_a: assert property (psel && !penable && paddr > `PMPC_OFS_INT_MASK
    |=> pslverr && prdata == 32'h0) else $error("unmapped access accepted");

  cover property (activeSec && !activePri);
  cover property (cfgProtRevert && $rose(activePri));
  cover property (fwdPri == 4'h4);
endmodule

bind pmpc_port_mode_ctrl pmpc_port_mode_monitor i_mon (.clk(clk), .rst_n(rst_n),
  .cfgDual(cfgDual), .cfgProtNonRev(cfgProtNonRev), .cfgProtRevert(cfgProtRevert),
  .primaryOpticalLinkUp(primaryOpticalLinkUp), .primaryOpticalFault(primaryOpticalFault),
  .standbyOpticalLinkUp(standbyOpticalLinkUp), .standbyOpticalFault(standbyOpticalFault),
  .fwdPri(fwdPri), .fwdSec(fwdSec), .fwdCuA(fwdCuA), .fwdCuB(fwdCuB),
  .activePri(activePri), .activeSec(activeSec), .standbySec(standbySec), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* tb/pmpc_link_model.sv */
// Behavioural model of the optical modules and copper drop ports
`timescale 1ns/1ns

module pmpc_link_model (
  input  wire logic clk,
  input  wire logic cutPri,
  input  wire logic flagPri,
  input  wire logic flagSec,
  output wire logic priUp,
  output wire logic priFlt,
  output wire logic secUp,
  output wire logic secFlt,
  output wire logic cuUp
);
  logic [2:0] st = 3'h4;

  // a cut fibre drops link, a sick module raises its flag
  always @(posedge clk) begin
    st <= {!cutPri, flagPri, flagSec};
  end
  assign priUp = st[2];
  assign priFlt = st[1];
  assign secFlt = st[0];
  assign secUp = 1'b1;
  assign cuUp = 1'b1;
endmodule

/* tb/tb_port_mode_protection_ctrl.sv */
// Self-checking bench for the port mode and protection controller
`timescale 1ns/1ns
`include "pmpc_params.svh"

module tb_port_mode_protection_ctrl;
  localparam int unsigned TICK = 4;
  logic clk = 1'b0, rst_n = 1'b0, cfgDual = 1'b0, cfgProtNonRev = 1'b0, cfgProtRevert = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, cutPri = 1'b0;
  logic flagPri = 1'b0, flagSec = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire logic [3:0] fwdPri, fwdSec, fwdCuA, fwdCuB;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq, activePri, activeSec, standbySec, pu, pf, su, sf, cu;
  int failures = 0;
  int samples_checked = 0;

  always #20 clk = ~clk;

  pmpc_link_model i_mod (.clk(clk), .cutPri(cutPri), .flagPri(flagPri), .flagSec(flagSec),
    .priUp(pu), .priFlt(pf), .secUp(su), .secFlt(sf), .cuUp(cu));
  pmpc_port_mode_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .rst_n(rst_n),
    .cfgDual(cfgDual), .cfgProtNonRev(cfgProtNonRev), .cfgProtRevert(cfgProtRevert),
    .spareSettingA(1'b0), .spareSettingB(1'b0), .primaryOpticalLinkUp(pu),
    .primaryOpticalFault(pf), .standbyOpticalLinkUp(su), .standbyOpticalFault(sf),
    .copperALinkUp(cu), .copperBLinkUp(cu), .fwdPri(fwdPri), .fwdSec(fwdSec),
    .fwdCuA(fwdCuA), .fwdCuB(fwdCuB), .activePri(activePri), .activeSec(activeSec),
    .standbySec(standbySec), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that sees pready; watchdog ends a hang
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_regs;
    apb(1'b0, `PMPC_OFS_HOLD, 32'h0);
    chk("hold", rd, 32'h0000000A);
    apb(1'b1, `PMPC_OFS_HOLD, 32'h1);
    apb(1'b0, `PMPC_OFS_HOLD, 32'h0);
    chk("hold", rd, 32'h00000001);
    apb(1'b0, `PMPC_OFS_INT_MASK, 32'h0);
    chk("mask", rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", er, 32'h1);
    chk("unmapped", rd, 32'h0);
    apb(1'b0, `PMPC_OFS_STATUS, 32'h0);
    chk("mode", rd[1:0], 32'h0);
    settle(60);
  endtask

  task t_modes;
    logic [2:0] k;
    logic p;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      p = k[2] | k[1];
      @(posedge clk);
      {cfgProtRevert, cfgProtNonRev, cfgDual} <= k;
      settle(2);
      chk("fwdPri", fwdPri, p ? 4'hC : k[0] ? 4'h4 : 4'hE);
      chk("fwdSec", fwdSec, p ? 4'h0 : k[0] ? 4'h8 : 4'hD);
      chk("fwdCuA", fwdCuA, p ? 4'h9 : k[0] ? 4'h1 : 4'hB);
      chk("standby", standbySec, p);
      apb(1'b0, `PMPC_OFS_STATUS, 32'h0);
      chk("mode", rd[1:0], k[2] ? 2'h2 : k[1] ? 2'h3 : k[0] ? 2'h1 : 2'h0);
    end
  endtask

  task t_nonrev;
    @(posedge clk);
    {cfgProtRevert, cfgProtNonRev, cfgDual} <= 3'b010;
    settle(2);
    apb(1'b0, `PMPC_OFS_INT_STAT, 32'h0);
    chk("intstat", rd, 32'h4);
    apb(1'b1, `PMPC_OFS_INT_MASK, 32'hF);
    @(posedge clk);
    cutPri <= 1'b1;
    settle(3);
    chk("actSec", activeSec, 1'b1);
    chk("fwdSec", fwdSec, 4'hC);
    chk("irq", irq, 1'b1);
    apb(1'b0, `PMPC_OFS_INT_STAT, 32'h0);
    chk("intstat", rd, 32'h9);
    apb(1'b0, `PMPC_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h000000F7);
    settle(2);
    chk("irq", irq, 1'b0);
    @(posedge clk);
    cutPri <= 1'b0;
    settle(4 * TICK);
    chk("actSec", activeSec, 1'b1);
    @(posedge clk);
    flagSec <= 1'b1;
    settle(3);
    chk("actPri", activePri, 1'b1);
    @(posedge clk);
    flagSec <= 1'b0;
  endtask

  task t_revert;
    @(posedge clk);
    {cfgProtRevert, cfgProtNonRev, cfgDual} <= 3'b100;
    settle(4 * TICK);
    apb(1'b0, `PMPC_OFS_INT_STAT, 32'h0);
    chk("intstat", rd, 32'h6);
    apb(1'b1, `PMPC_OFS_INT_MASK, 32'h0);
    @(posedge clk);
    flagPri <= 1'b1;
    settle(3);
    chk("actSec", activeSec, 1'b1);
    chk("irq", irq, 1'b0);
    @(posedge clk);
    flagPri <= 1'b0;
    settle(4 * TICK);
    chk("actPri", activePri, 1'b1);
    chk("standby", standbySec, 1'b1);
    apb(1'b1, `PMPC_OFS_INT_MASK, 32'hF);
    settle(2);
    chk("irq", irq, 1'b1);
    apb(1'b0, `PMPC_OFS_INT_STAT, 32'h0);
    chk("intstat", rd, 32'hB);
  endtask

  task give_verdict;
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_modes();
    t_nonrev();
    t_revert();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
